// [shared/tcc_defines.vh]
// Shared constants for the transceiver core control register bank
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// Serial bus slave address, 7 bits
`define TCC_SLAVE_ADDR 7'h08

// Register indices as sent in the register address byte
`define TCC_REG_CORE0 8'h00
`define TCC_REG_CORE1 8'h01
`define TCC_REG_CORE2 8'h02
`define TCC_REG_CORE3 8'h03
`define TCC_REG_CONV_MSB 8'h28
`define TCC_REG_CONV_LSB 8'h29

// Reset values
`define TCC_CORE0_RST 8'h41
`define TCC_CORE1_RST 8'h00
`define TCC_CORE2_RST 8'h00
`define TCC_CORE3_RST 8'h00

// Core register 0 fields
`define TCC_C0_GLOBAL_RST 7
`define TCC_C0_REG_RST 1
`define TCC_C0_CHIP_EN 0
`define TCC_C0_STORE_MASK 8'h7D

// Core register 1 fields
`define TCC_C1_PD_TRIG 7
`define TCC_C1_PD_RNG_HI 6
`define TCC_C1_PD_RNG_LO 5
`define TCC_C1_OPEN_LOOP 4
`define TCC_C1_FAULT_EN 3
`define TCC_C1_BIAS_EN 2
`define TCC_C1_BIAS_SINK 1
`define TCC_C1_PD_POL 0

// Core register 2 fields
`define TCC_C2_OPT_LB 1
`define TCC_C2_ELEC_LB 0

// Core register 3 fields
`define TCC_C3_CONV_EN 7
`define TCC_C3_OSC_EN 6
`define TCC_C3_CONV_RST 4
`define TCC_C3_SEL_MSB 2
`define TCC_C3_SEL_RSV 2

`endif

// [hw/tcc_pin_sync.v]
// Two-flop synchroniser for a group of asynchronous input pins
`timescale 1ns/100ps
module tcc_pin_sync #(
   parameter WIDTH = 4
) (
   input wire ref_clk,
   input wire nrst,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   // Idle level of open-drain lines is high, so reset to ones avoids a false start
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= {WIDTH{1'b1}};
         sync_ff <= {WIDTH{1'b1}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

// [hw/tcc_ctrl_regs.v]
// Core control register bank with two-wire serial slave
`timescale 1ns/100ps
`include "tcc_defines.vh"
module tcc_ctrl_regs #(
   parameter [6:0] SLAVE_ADDR = `TCC_SLAVE_ADDR
) (
   input wire ref_clk,
   input wire nrst,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   input wire [9:0] conv_result,
   input wire pd_monitor_pin,
   input wire bias_fault_in,
   input wire tx_recovered_data,
   input wire rx_recovered_data,
   output wire rx_out_data,
   output wire tx_out_data,
   output wire global_soft_reset,
   output wire chip_enable,
   output wire pd_monitor_fault_trigger,
   output wire pd_range_high,
   output wire pd_range_low,
   output wire open_loop_select,
   output wire fault_detect_enable,
   output wire laser_bias_enable,
   output wire bias_sink_select,
   output wire photodiode_polarity,
   output wire laser_bias_on,
   output wire laser_fault,
   output wire optical_loopback_select,
   output wire electrical_loopback_select,
   output wire converter_enable,
   output wire converter_osc_enable,
   output wire converter_reset,
   output wire [2:0] converter_input_select,
   output wire converter_select_valid
);
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_ADDR_ACK = 4'h2;
   localparam [3:0] ST_REG = 4'h3;
   localparam [3:0] ST_REG_ACK = 4'h4;
   localparam [3:0] ST_WDATA = 4'h5;
   localparam [3:0] ST_WDATA_ACK = 4'h6;
   localparam [3:0] ST_RDATA = 4'h7;
   localparam [3:0] ST_RDATA_ACK = 4'h8;
   localparam [3:0] ST_IGNORE = 4'h9;

   wire [3:0] pins_s;
   wire scl_s;
   wire sda_s;
   wire pd_pin_s;
   wire fault_s;

   reg scl_q_ff;
   reg sda_q_ff;
   reg [3:0] state_ff;
   reg [2:0] bit_cnt_ff;
   reg got_byte_ff;
   reg [7:0] rx_sh_ff;
   reg [7:0] tx_sh_ff;
   reg [7:0] ptr_ff;
   reg sda_oe_ff;
   reg glob_pend_ff;
   reg regrst_pend_ff;
   reg glob_pulse_ff;
   reg [7:0] core0_ff;
   reg [7:0] core1_ff;
   reg [7:0] core2_ff;
   reg [7:0] core3_ff;
   reg fault_ff;
   reg rx_out_ff;
   reg tx_out_ff;

   reg [3:0] nxt_state;
   reg [2:0] nxt_bit_cnt;
   reg nxt_got_byte;
   reg [7:0] nxt_rx_sh;
   reg [7:0] nxt_tx_sh;
   reg [7:0] nxt_ptr;
   reg nxt_sda_oe;
   reg nxt_glob_pend;
   reg nxt_regrst_pend;
   reg nxt_glob_pulse;
   reg [7:0] nxt_core0;
   reg [7:0] nxt_core1;
   reg [7:0] nxt_core2;
   reg [7:0] nxt_core3;
   reg [7:0] rd_data;

   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire fault_src;

   tcc_pin_sync #(
      .WIDTH(4)
   ) u_pin_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in({bias_fault_in, pd_monitor_pin, sda_in, scl_in}),
      .sync_out(pins_s)
   );

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign pd_pin_s = pins_s[2];
   assign fault_s = pins_s[3];

   assign scl_rise = scl_s & ~scl_q_ff;
   assign scl_fall = ~scl_s & scl_q_ff;
   assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

   // Read multiplexer; unmapped indices read as zero
   always @* begin
      case (ptr_ff)
         `TCC_REG_CORE0: rd_data = core0_ff & `TCC_C0_STORE_MASK;
         `TCC_REG_CORE1: rd_data = core1_ff;
         `TCC_REG_CORE2: rd_data = core2_ff;
         `TCC_REG_CORE3: rd_data = core3_ff;
         `TCC_REG_CONV_MSB: rd_data = conv_result[9:2];
         `TCC_REG_CONV_LSB: rd_data = {6'h00, conv_result[1:0]};
         default: rd_data = 8'h00;
      endcase
   end

   // Serial slave sequencing and register writes
   always @* begin
      nxt_state = state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_got_byte = got_byte_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_ptr = ptr_ff;
      nxt_sda_oe = sda_oe_ff;
      nxt_glob_pend = glob_pend_ff;
      nxt_regrst_pend = regrst_pend_ff;
      nxt_glob_pulse = 1'b0;
      nxt_core0 = core0_ff;
      nxt_core1 = core1_ff;
      nxt_core2 = core2_ff;
      nxt_core3 = core3_ff;
      if (start_det) begin
         nxt_state = ST_ADDR;
         nxt_bit_cnt = 3'h0;
         nxt_got_byte = 1'b0;
         nxt_sda_oe = 1'b0;
      end else if (stop_det) begin
         nxt_state = ST_IDLE;
         nxt_sda_oe = 1'b0;
      end else begin
         case (state_ff)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (scl_rise) begin
                  nxt_rx_sh = {rx_sh_ff[6:0], sda_s};
                  nxt_bit_cnt = bit_cnt_ff + 3'h1;
                  nxt_got_byte = (bit_cnt_ff == 3'h7);
               end else if (scl_fall && got_byte_ff) begin
                  nxt_got_byte = 1'b0;
                  nxt_bit_cnt = 3'h0;
                  nxt_sda_oe = 1'b1;
                  if (state_ff == ST_ADDR) begin
                     if (rx_sh_ff[7:1] == SLAVE_ADDR) begin
                        nxt_state = ST_ADDR_ACK;
                     end else begin
                        // Foreign address: leave the line high
                        nxt_sda_oe = 1'b0;
                        nxt_state = ST_IGNORE;
                     end
                  end else if (state_ff == ST_REG) begin
                     nxt_ptr = rx_sh_ff;
                     nxt_state = ST_REG_ACK;
                  end else begin
                     nxt_state = ST_WDATA_ACK;
                     case (ptr_ff)
                        `TCC_REG_CORE0: begin
                           // Reserved bits 6:2 keep what is written
                           nxt_core0 = rx_sh_ff & `TCC_C0_STORE_MASK;
                           nxt_glob_pend = rx_sh_ff[`TCC_C0_GLOBAL_RST];
                           nxt_regrst_pend = rx_sh_ff[`TCC_C0_REG_RST];
                        end
                        `TCC_REG_CORE1: nxt_core1 = rx_sh_ff;
                        `TCC_REG_CORE2: nxt_core2 = rx_sh_ff;
                        `TCC_REG_CORE3: nxt_core3 = rx_sh_ff;
                        default: nxt_core0 = core0_ff;
                     endcase
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rx_sh_ff[0]) begin
                     // Read uses the pointer left by the last write
                     nxt_tx_sh = rd_data;
                     nxt_sda_oe = ~rd_data[7];
                     nxt_state = ST_RDATA;
                  end else begin
                     nxt_sda_oe = 1'b0;
                     nxt_state = ST_REG;
                  end
               end
            end
            ST_REG_ACK: begin
               if (scl_fall) begin
                  nxt_sda_oe = 1'b0;
                  nxt_state = ST_WDATA;
               end
            end
            ST_WDATA_ACK: begin
               if (scl_fall) begin
                  nxt_sda_oe = 1'b0;
                  // Extra bytes are not acknowledged
                  nxt_state = ST_IGNORE;
                  // Soft resets act after the acknowledge so the bus sees a clean end
                  if (glob_pend_ff || regrst_pend_ff) begin
                     nxt_core0 = `TCC_CORE0_RST;
                     nxt_core1 = `TCC_CORE1_RST;
                     nxt_core2 = `TCC_CORE2_RST;
                     nxt_core3 = `TCC_CORE3_RST;
                  end
                  if (glob_pend_ff) begin
                     nxt_ptr = 8'h00;
                     nxt_glob_pulse = 1'b1;
                     nxt_state = ST_IDLE;
                  end
                  nxt_glob_pend = 1'b0;
                  nxt_regrst_pend = 1'b0;
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  nxt_bit_cnt = bit_cnt_ff + 3'h1;
                  nxt_got_byte = (bit_cnt_ff == 3'h7);
               end else if (scl_fall) begin
                  if (got_byte_ff) begin
                     nxt_got_byte = 1'b0;
                     nxt_sda_oe = 1'b0;
                     nxt_state = ST_RDATA_ACK;
                  end else begin
                     nxt_sda_oe = ~tx_sh_ff[3'h7 - bit_cnt_ff];
                  end
               end
            end
            ST_RDATA_ACK: begin
               if (scl_rise) begin
                  nxt_state = ST_IGNORE;
               end
            end
            ST_IDLE, ST_IGNORE: begin
               nxt_sda_oe = 1'b0;
            end
            default: begin
               nxt_state = ST_IDLE;
               nxt_sda_oe = 1'b0;
            end
         endcase
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 3'h0;
         got_byte_ff <= 1'b0;
         rx_sh_ff <= 8'h00;
         tx_sh_ff <= 8'h00;
         ptr_ff <= 8'h00;
         sda_oe_ff <= 1'b0;
         glob_pend_ff <= 1'b0;
         regrst_pend_ff <= 1'b0;
         glob_pulse_ff <= 1'b0;
         core0_ff <= `TCC_CORE0_RST;
         core1_ff <= `TCC_CORE1_RST;
         core2_ff <= `TCC_CORE2_RST;
         core3_ff <= `TCC_CORE3_RST;
      end else begin
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
         state_ff <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         got_byte_ff <= nxt_got_byte;
         rx_sh_ff <= nxt_rx_sh;
         tx_sh_ff <= nxt_tx_sh;
         ptr_ff <= nxt_ptr;
         sda_oe_ff <= nxt_sda_oe;
         glob_pend_ff <= nxt_glob_pend;
         regrst_pend_ff <= nxt_regrst_pend;
         glob_pulse_ff <= nxt_glob_pulse;
         core0_ff <= nxt_core0;
         core1_ff <= nxt_core1;
         core2_ff <= nxt_core2;
         core3_ff <= nxt_core3;
      end
   end

   // Fault sources; the monitor pin counts only when its trigger is armed
   assign fault_src = core1_ff[`TCC_C1_FAULT_EN] &
      (fault_s | (core1_ff[`TCC_C1_PD_TRIG] & pd_pin_s));

   // Latched fault: a new fault wins over the clear by bias disable
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fault_ff <= 1'b0;
      end else if (fault_src) begin
         fault_ff <= 1'b1;
      end else if (!core1_ff[`TCC_C1_BIAS_EN]) begin
         fault_ff <= 1'b0;
      end
   end

   // Loopback muxes, registered so the outputs are glitch free
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rx_out_ff <= 1'b0;
         tx_out_ff <= 1'b0;
      end else begin
         rx_out_ff <= core2_ff[`TCC_C2_OPT_LB] ? tx_recovered_data : rx_recovered_data;
         tx_out_ff <= core2_ff[`TCC_C2_ELEC_LB] ? rx_recovered_data : tx_recovered_data;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = sda_oe_ff;
   assign rx_out_data = rx_out_ff;
   assign tx_out_data = tx_out_ff;
   assign global_soft_reset = glob_pulse_ff;
   assign chip_enable = core0_ff[`TCC_C0_CHIP_EN];
   assign pd_monitor_fault_trigger = core1_ff[`TCC_C1_PD_TRIG];
   assign pd_range_high = core1_ff[`TCC_C1_PD_RNG_HI];
   assign pd_range_low = core1_ff[`TCC_C1_PD_RNG_LO];
   assign open_loop_select = core1_ff[`TCC_C1_OPEN_LOOP];
   assign fault_detect_enable = core1_ff[`TCC_C1_FAULT_EN];
   assign laser_bias_enable = core1_ff[`TCC_C1_BIAS_EN];
   assign bias_sink_select = core1_ff[`TCC_C1_BIAS_SINK];
   assign photodiode_polarity = core1_ff[`TCC_C1_PD_POL];
   assign laser_bias_on = core0_ff[`TCC_C0_CHIP_EN] & core1_ff[`TCC_C1_BIAS_EN] & ~fault_ff;
   assign laser_fault = fault_ff;
   assign optical_loopback_select = core2_ff[`TCC_C2_OPT_LB];
   assign electrical_loopback_select = core2_ff[`TCC_C2_ELEC_LB];
   assign converter_enable = core3_ff[`TCC_C3_CONV_EN];
   assign converter_osc_enable = core3_ff[`TCC_C3_OSC_EN];
   assign converter_reset = core3_ff[`TCC_C3_CONV_RST];
   assign converter_input_select = core3_ff[`TCC_C3_SEL_MSB:0];
   // Reserved codes still pass through; downstream may ignore them
   assign converter_select_valid = ~core3_ff[`TCC_C3_SEL_RSV];
endmodule

// [verification/tcc_ctrl_regs_props.sv]
// Checker for the core control register bank
`timescale 1ns/100ps
module tcc_ctrl_regs_props (
   input wire ref_clk,
   input wire nrst,
   input wire sda_out,
   input wire sda_oe,
   input wire bias_fault_in,
   input wire tx_recovered_data,
   input wire rx_recovered_data,
   input wire rx_out_data,
   input wire tx_out_data,
   input wire global_soft_reset,
   input wire chip_enable,
   input wire fault_detect_enable,
   input wire laser_bias_enable,
   input wire laser_bias_on,
   input wire laser_fault,
   input wire optical_loopback_select,
   input wire electrical_loopback_select,
   input wire converter_enable,
   input wire converter_osc_enable,
   input wire [2:0] converter_input_select,
   input wire converter_select_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Two sync flops plus the fault latch, so four cycles of cause
   sequence s_fault_cause;
      (fault_detect_enable && bias_fault_in) [*4];
   endsequence
   sequence s_drive_span;
      sda_oe [*8];
   endsequence
   AST_OPEN_DRAIN: assert property (sda_oe |-> !sda_out)
      else $error("data pin driven high");
   AST_ACK_SPAN: assert property ($rose(sda_oe) |-> s_drive_span)
      else $error("data drive too short");
   AST_RESET_VALS: assert property ($rose(nrst) |-> chip_enable && !laser_bias_enable &&
      !converter_enable && !converter_osc_enable && !sda_oe) else $error("bad reset value");
   AST_BIAS_ON: assert property (laser_bias_on == (chip_enable && laser_bias_enable &&
      !laser_fault)) else $error("bias on mismatch");
   AST_FAULT_SET: assert property (s_fault_cause |-> laser_fault)
      else $error("fault not latched");
   AST_FAULT_KEEP: assert property (laser_fault && laser_bias_enable |=>
      laser_fault || !laser_bias_enable) else $error("fault cleared early");
   AST_RX_MUX: assert property ($past(nrst) |-> rx_out_data ==
      $past(optical_loopback_select ? tx_recovered_data : rx_recovered_data))
      else $error("receive mux wrong");
   AST_TX_MUX: assert property ($past(nrst) |-> tx_out_data ==
      $past(electrical_loopback_select ? rx_recovered_data : tx_recovered_data))
      else $error("transmit mux wrong");
   AST_GSR_PULSE: assert property (global_soft_reset |=> !global_soft_reset)
      else $error("reset pulse too long");
   AST_GSR_DEFAULTS: assert property (global_soft_reset |-> ##[0:2] (chip_enable &&
      !converter_enable && !optical_loopback_select)) else $error("registers not reset");
   AST_SEL_VALID: assert property (converter_select_valid == !converter_input_select[2])
      else $error("select valid wrong");
endmodule

// [verification/tcc_host.sv]
// Two-wire bus host model driving the register bank
`timescale 1ns/100ps
`include "tcc_defines.vh"
module tcc_host (
   input wire ref_clk,
   input wire sda_line,
   output logic scl,
   output logic sda_oe
);
   localparam int HALF = 8;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Data moves two cycles after the clock falls, eight cycles before it rises again
   task automatic bit_io(input logic b, output logic s);
      wt(2);
      sda_oe <= !b;
      wt(HALF);
      scl <= 1'b1;
      wt(HALF / 2);
      #1 s = sda_line;
      wt(HALF / 2);
      scl <= 1'b0;
   endtask
   task automatic start;
      wt(2);
      sda_oe <= 1'b0;
      wt(HALF);
      scl <= 1'b1;
      wt(HALF);
      sda_oe <= 1'b1;
      wt(HALF);
      scl <= 1'b0;
   endtask
   task automatic stop;
      wt(2);
      sda_oe <= 1'b1;
      wt(HALF);
      scl <= 1'b1;
      wt(HALF);
      sda_oe <= 1'b0;
      wt(HALF);
   endtask
   task automatic byte_w(input logic [7:0] b, output logic ok);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ok = !s;
   endtask
   task automatic byte_r(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(1'b1, s);
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start;
      byte_w({`TCC_SLAVE_ADDR, 1'b0}, k0);
      byte_w(a, k1);
      byte_w(d, k2);
      stop;
      ok = k0 & k1 & k2;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start;
      byte_w({`TCC_SLAVE_ADDR, 1'b0}, k0);
      byte_w(a, k1);
      start;
      byte_w({`TCC_SLAVE_ADDR, 1'b1}, k2);
      byte_r(d);
      stop;
      ok = k0 & k1 & k2;
   endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for the core control register bank
`timescale 1ns/100ps
module tb;
   typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [7:0] m;} tcc_row_t;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic bias_fault_in = 1'b0;
   logic pd_monitor_pin = 1'b0;
   logic tx_rd = 1'b0;
   logic rx_rd = 1'b0;
   logic [9:0] conv_result = 10'h2b6;
   logic [7:0] pulses = 8'h00;
   logic ok;
   int fails = 0;
   int checks = 0;
   wire host_scl, host_oe, dut_sda, dut_oe, rx_out, tx_out, gsr, chip_en, bias_on, fault, sel_ok;
   wire [7:0] r1_v;
   wire [1:0] r2_v;
   wire [5:0] r3_v;
   wire sda_wire = (dut_oe ? dut_sda : 1'b1) & !host_oe;
   tcc_row_t rows [10] = '{'{8'h01, 8'ha5, 8'ha5, 8'hff}, '{8'h01, 8'h5a, 8'h5a, 8'hff},
      '{8'h02, 8'hf1, 8'hf1, 8'h03}, '{8'h02, 8'h02, 8'h02, 8'h03}, '{8'h03, 8'hd7, 8'hd7, 8'hd7},
      '{8'h03, 8'h28, 8'h28, 8'hd7}, '{8'h03, 8'h04, 8'h04, 8'hd7}, '{8'h00, 8'h7c, 8'h7c, 8'h01},
      '{8'h00, 8'h41, 8'h41, 8'h01}, '{8'h05, 8'hff, 8'h00, 8'h00}};
   tcc_ctrl_regs tcc_ctrl_regs_i (.ref_clk(ref_clk), .nrst(nrst), .scl_in(host_scl),
      .sda_in(sda_wire), .sda_out(dut_sda), .sda_oe(dut_oe), .conv_result(conv_result),
      .pd_monitor_pin(pd_monitor_pin), .bias_fault_in(bias_fault_in),
      .tx_recovered_data(tx_rd), .rx_recovered_data(rx_rd), .rx_out_data(rx_out),
      .tx_out_data(tx_out), .global_soft_reset(gsr), .chip_enable(chip_en),
      .pd_monitor_fault_trigger(r1_v[7]), .pd_range_high(r1_v[6]), .pd_range_low(r1_v[5]),
      .open_loop_select(r1_v[4]), .fault_detect_enable(r1_v[3]), .laser_bias_enable(r1_v[2]),
      .bias_sink_select(r1_v[1]), .photodiode_polarity(r1_v[0]), .laser_bias_on(bias_on),
      .laser_fault(fault), .optical_loopback_select(r2_v[1]),
      .electrical_loopback_select(r2_v[0]), .converter_enable(r3_v[5]),
      .converter_osc_enable(r3_v[4]), .converter_reset(r3_v[3]),
      .converter_input_select(r3_v[2:0]), .converter_select_valid(sel_ok));
   tcc_host tcc_host_i (.ref_clk(ref_clk), .sda_line(sda_wire), .scl(host_scl), .sda_oe(host_oe));
   always #5 ref_clk = ~ref_clk;
   // Two rates so both mux legs differ often
   always @(posedge ref_clk) begin
      tx_rd <= ~tx_rd;
      if (tx_rd) rx_rd <= ~rx_rd;
      if (gsr === 1'b1) pulses <= pulses + 8'h01;
   end
   function automatic logic [7:0] view(input logic [7:0] a);
      case (a)
         8'h00: view = {7'h00, chip_en};
         8'h01: view = r1_v;
         8'h02: view = {6'h00, r2_v};
         8'h03: view = {r3_v[5:4], 1'b0, r3_v[3], 1'b0, r3_v[2:0]};
         default: view = 8'h00;
      endcase
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic k;
      tcc_host_i.write_reg(a, d, k);
      check({7'h00, k}, 8'h01);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic k;
      tcc_host_i.read_reg(a, d, k);
      check({7'h00, k}, 8'h01);
      check(d, exp);
   endtask
   task automatic pulse_pin(input bit pd);
      if (pd) pd_monitor_pin <= 1'b1;
      else bias_fault_in <= 1'b1;
      repeat (8) @(posedge ref_clk);
      pd_monitor_pin <= 1'b0;
      bias_fault_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   initial begin
      repeat (95000) @(posedge ref_clk);
      fails++;
      $display("mismatch at %0t: run limit reached", $time);
      close_out;
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) rdc(i[7:0], i == 0 ? 8'h41 : 8'h00);
      $display("test reset values done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].r);
         check(view(rows[i].a) & rows[i].m, rows[i].r & rows[i].m);
      end
      $display("test register rows done");
      wr(8'h00, 8'h43);
      rdc(8'h01, 8'h00);
      rdc(8'h00, 8'h41);
      wr(8'h03, 8'hd7);
      wr(8'h00, 8'h80);
      check(pulses, 8'h01);
      rdc(8'h03, 8'h00);
      $display("test soft resets done");
      tcc_host_i.start;
      tcc_host_i.byte_w(8'h12, ok);
      check({7'h00, ok}, 8'h00);
      tcc_host_i.stop;
      tcc_host_i.start;
      tcc_host_i.byte_w(8'h10, ok);
      tcc_host_i.byte_w(8'h01, ok);
      tcc_host_i.byte_w(8'h33, ok);
      tcc_host_i.byte_w(8'h44, ok);
      check({7'h00, ok}, 8'h00);
      tcc_host_i.stop;
      rdc(8'h01, 8'h33);
      rdc(8'h28, 8'had);
      rdc(8'h29, 8'h02);
      $display("test bus refusals done");
      wr(8'h01, 8'h0c);
      pulse_pin(1'b0);
      check({6'h00, fault, bias_on}, 8'h02);
      wr(8'h01, 8'h08);
      check({7'h00, fault}, 8'h00);
      wr(8'h01, 8'h8c);
      pulse_pin(1'b1);
      check({7'h00, fault}, 8'h01);
      wr(8'h01, 8'h88);
      wr(8'h01, 8'h0c);
      check({6'h00, fault, bias_on}, 8'h01);
      $display("test fault latch done");
      nrst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdc(8'h01, 8'h00);
      $display("test second reset done");
      close_out;
   end
endmodule
bind tcc_ctrl_regs tcc_ctrl_regs_props tcc_ctrl_regs_props_i (.*);
